/* File: rtl/qr_pulse_control.sv */
// Pulse sequencing core of a quasi-resonant flyback controller
//
// Operation
// R01 - Fault latch enables the 6 V clamp; it releases once supply drops below 4 V.
// R02 - In fault mode the undervoltage stop halts gate pulses with priority.
// R03 - Undervoltage while the fault timer counts stops pulses and enters latch-off.
// R04 - Each gate rise starts an 8 us minimum period, capping frequency at 125 kHz.
// R05 - Peak current reaching the setpoint resets the drive and ends the on-time.
// R06 - On-time beyond 50 us stops pulses and enters auto-recovery restart.
// R07 - A 3 us blanking window after turn-off suppresses any restart.
// R08 - Core reset is the rising edge of the auxiliary below-45 mV comparator.
// R09 - A demag edge inside the minimum period is ignored; a later one is awaited.
// R10 - While skip holds the drive reset, demag edges are ignored.
// R11 - An 8 us timeout, reloaded at each crossing, becomes the restart signal.
// R12 - Timeout restarts at once if skip is released, else waits for release.
// R13 - The peak setpoint stops falling at a floor; burst operation takes over.
// R14 - Feedback at the burst threshold resets the drive and stops pulses.
// R15 - Pulses resume only once feedback rises above threshold plus hysteresis.
// R16 - Every skip release re-runs the soft-start ramp.
// R17 - Soft-start raises the peak current limit to maximum over about 5 ms.
// R18 - Intervals are clock counters; comparator outputs are synchronised first.
// R19 - Fault latch, restart phase or undervoltage force the gate low.
`timescale 1ns/1ns
`default_nettype none
module qr_pulse_control
   import qr_pulse_pkg::*;
#(
   parameter int SS_CYC = SOFT_START_CYC,
   parameter int RESTART_CYC = AUTO_RESTART_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire comp_t comparators,
   input wire logic [SETPOINT_W-1:0] feedback_input,
   output logic gate_drive_output,
   output logic [SETPOINT_W-1:0] peak_setpoint,
   output status_t status
);
   localparam int STEP_CYC = SS_CYC / RAMP_STEPS;
   localparam int STEP_W = $clog2(STEP_CYC + 1);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
   localparam int RST_W = $clog2(RESTART_CYC + 1);
   localparam logic [RST_W-1:0] RESTART_LOAD = RST_W'(RESTART_CYC);
   localparam logic [SETPOINT_W-1:0] RAMP_ONE = SETPOINT_W'(1);

   generate
      if (SS_CYC < RAMP_STEPS) begin : g_bad_ss
         $error("SS_CYC must be at least RAMP_STEPS");
      end
      if (RESTART_CYC < 1) begin : g_bad_rst
         $error("RESTART_CYC must be at least 1");
      end
   endgenerate

   comp_t cs;
   logic demag_prev;
   logic drive;
   logic skip_hold;
   logic fault_latched;
   logic latchoff;
   logic restart_mode;
   logic [RST_W-1:0] restart_cnt;
   logic [SETPOINT_W-1:0] ramp;
   logic [STEP_W-1:0] step_cnt;
   logic ramp_tick;
   logic min_busy;
   logic blank_busy;
   logic on_busy;
   logic timeout_busy;
   logic demag_edge;
   logic crossing;
   logic halt;
   logic on_expired;
   logic turn_on;
   logic turn_off;
   logic ramp_restart;
   logic [SETPOINT_W-1:0] fb_floored;
   logic [SETPOINT_W-1:0] next_setpoint;

   // Comparator outputs cross into the clock domain first
   qr_sync2 #(.W(COMP_W)) u_sync ( // R18
      .sys_clk(sys_clk),
      .rst(rst),
      .d(comparators),
      .q(cs)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         demag_prev <= 1'b0;
      end else begin
         demag_prev <= cs.demag_low;
      end
   end

   assign demag_edge = cs.demag_low & ~demag_prev; // R08
   assign crossing = demag_edge & ~blank_busy; // R07
   assign halt = fault_latched | latchoff | restart_mode | cs.uv_stop; // R19 R02
   assign on_expired = drive & ~on_busy; // R06

   // Restart needs the period elapsed, skip released and a valid edge or timeout
   assign turn_on = ~drive & ~min_busy & ~skip_hold & ~halt & ~cs.skip_low // R09 R10 R12
      & ~blank_busy & (crossing | ~timeout_busy); // R11
   assign turn_off = drive & (cs.peak_hit | cs.skip_low | skip_hold | halt | on_expired);

   // Gate drive flip-flop: reset terms win over the set term
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         drive <= 1'b0;
      end else if (turn_off) begin
         drive <= 1'b0; // R05 R14 R19
      end else if (turn_on) begin
         drive <= 1'b1;
      end
   end

   qr_interval_timer #(.COUNT(MIN_PERIOD_CYC)) u_min_period ( // R04
      .sys_clk(sys_clk),
      .rst(rst),
      .start(turn_on),
      .busy(min_busy)
   );

   qr_interval_timer #(.COUNT(BLANK_CYC)) u_blank ( // R07
      .sys_clk(sys_clk),
      .rst(rst),
      .start(turn_off),
      .busy(blank_busy)
   );

   qr_interval_timer #(.COUNT(MAX_ON_CYC)) u_max_on ( // R06
      .sys_clk(sys_clk),
      .rst(rst),
      .start(turn_on),
      .busy(on_busy)
   );

   // Reloaded at each valid ringing crossing and at turn-off
   qr_interval_timer #(.COUNT(TIMEOUT_CYC)) u_timeout ( // R11
      .sys_clk(sys_clk),
      .rst(rst),
      .start(crossing | turn_off),
      .busy(timeout_busy)
   );

   // Burst hold with hysteresis; a new skip request wins over release
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         skip_hold <= 1'b0;
      end else if (cs.skip_low) begin
         skip_hold <= 1'b1; // R14
      end else if (cs.skip_clear) begin
         skip_hold <= 1'b0; // R15
      end
   end

   // Latched fault and supply clamp
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fault_latched <= 1'b0;
      end else if (cs.fault_req) begin
         fault_latched <= 1'b1; // R01
      end else if (cs.supply_low) begin
         fault_latched <= 1'b0; // R01
      end
   end

   // Latch-off phase held until the supply recovers above the stop level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latchoff <= 1'b0;
      end else if (cs.uv_stop & cs.fault_timing) begin
         latchoff <= 1'b1; // R03
      end else if (~cs.uv_stop) begin
         latchoff <= 1'b0;
      end
   end

   // Auto-recovery hold after an overlong on-time
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         restart_mode <= 1'b0;
         restart_cnt <= '0;
      end else if (on_expired) begin
         restart_mode <= 1'b1; // R06
         restart_cnt <= RESTART_LOAD;
      end else if (restart_cnt != '0) begin
         restart_cnt <= restart_cnt - RST_W'(1);
      end else begin
         restart_mode <= 1'b0;
      end
   end

   // Soft-start step enable divider
   always_ff @(posedge sys_clk) begin
      if (rst || ramp_restart) begin
         step_cnt <= '0;
      end else if (step_cnt == STEP_LAST) begin
         step_cnt <= '0;
      end else begin
         step_cnt <= step_cnt + STEP_W'(1);
      end
   end

   assign ramp_tick = (step_cnt == STEP_LAST);
   assign ramp_restart = (skip_hold & cs.skip_clear & ~cs.skip_low) | halt; // R16

   always_ff @(posedge sys_clk) begin
      if (rst || ramp_restart) begin
         ramp <= SETPOINT_RESET; // R16
      end else if (ramp_tick && ramp != SETPOINT_MAX) begin
         ramp <= ramp + RAMP_ONE; // R17
      end
   end

   // Demand never goes below the floor; the ramp caps it
   always_comb begin
      fb_floored = (feedback_input < SETPOINT_FLOOR) ? SETPOINT_FLOOR : feedback_input; // R13
      next_setpoint = (ramp < fb_floored) ? ramp : fb_floored; // R17
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         peak_setpoint <= SETPOINT_RESET;
         status <= '0;
      end else begin
         peak_setpoint <= next_setpoint;
         status.clamp_on <= fault_latched; // R01
         status.latchoff <= latchoff;
         status.restart_mode <= restart_mode;
         status.skip_active <= skip_hold;
      end
   end

   assign gate_drive_output = drive;

   // Helper counters for the checks below
   logic [15:0] since_rise;
   logic [15:0] since_fall;
   logic [15:0] on_len;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         since_rise <= 16'hFFFF;
         since_fall <= 16'hFFFF;
         on_len <= 16'h0000;
      end else begin
         since_rise <= turn_on ? 16'h0000
            : (since_rise == 16'hFFFF ? since_rise : since_rise + 16'h0001);
         since_fall <= turn_off ? 16'h0000
            : (since_fall == 16'hFFFF ? since_fall : since_fall + 16'h0001);
         on_len <= drive ? on_len + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_peak_ends_on: assert property (drive && cs.peak_hit |=> !drive) // R05
      else $error("drive stayed high after peak current");
   chk_min_period: assert property (turn_on |-> since_rise >= 16'(MIN_PERIOD_CYC - 1)) // R04 R09
      else $error("restart inside minimum period");
   chk_blank_window: assert property (turn_on |-> since_fall >= 16'(BLANK_CYC - 1)) // R07
      else $error("restart inside blanking window");
   chk_max_on_len: assert property (on_len <= 16'(MAX_ON_CYC + 1)) // R06
      else $error("on-time exceeded maximum");
   chk_max_on_restart: assert property (on_expired |=> restart_mode && !drive ##1 !drive) // R06
      else $error("overlong on-time did not enter restart");
   chk_skip_stops: assert property (skip_hold |=> !drive) // R10 R14
      else $error("pulse while skip holds drive reset");
   chk_halt_low: assert property (halt |=> !drive) // R19 R02
      else $error("gate high during halt");
   chk_uv_latchoff: assert property (cs.uv_stop && cs.fault_timing |=> latchoff && !drive) // R03
      else $error("undervoltage during fault timer missed latch-off");
   chk_clamp_hold: assert property (fault_latched && !cs.supply_low // R01
      |=> fault_latched ##1 status.clamp_on)
      else $error("clamp released early");
   chk_soft_restart: assert property ($fell(skip_hold) && !halt |-> ramp == SETPOINT_RESET) // R16
      else $error("soft-start not restarted on skip release");
endmodule
`default_nettype wire

/* File: rtl/qr_pulse_pkg.sv */
// Shared constants and carrier types for the quasi-resonant pulse controller
package qr_pulse_pkg;
   localparam int CLK_MHZ = 20;
   localparam int NS_PER_US = 1000;

   // Least times round up to whole cycles, longest times round down
   localparam int MIN_PERIOD_NS = 8000;
   localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int BLANK_NS = 3000;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int MAX_ON_NS = 50000;
   localparam int MAX_ON_CYC = (MAX_ON_NS * CLK_MHZ) / NS_PER_US;
   localparam int TIMEOUT_NS = 8000;
   localparam int TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int SOFT_START_US = 5000;
   localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
   localparam int AUTO_RESTART_US = 5000;
   localparam int AUTO_RESTART_CYC = AUTO_RESTART_US * CLK_MHZ;

   localparam int SETPOINT_W = 8;
   localparam int RAMP_STEPS = 256;
   localparam logic [SETPOINT_W-1:0] SETPOINT_MAX = 8'hFF;
   localparam logic [SETPOINT_W-1:0] SETPOINT_FLOOR = 8'h20;
   localparam logic [SETPOINT_W-1:0] SETPOINT_RESET = 8'h00;

   // Digital outputs of the analog comparators, all asynchronous to sys_clk
   typedef struct packed {
      logic peak_hit;     // Sensed current at or above the setpoint
      logic demag_low;    // Auxiliary winding below the core reset level
      logic skip_low;     // Feedback at or below the burst threshold
      logic skip_clear;   // Feedback above burst threshold plus hysteresis
      logic uv_stop;      // Supply below the undervoltage stop level
      logic supply_low;   // Supply below the latch release level
      logic fault_req;    // Latching fault request
      logic fault_timing; // Fault timer is counting
   } comp_t;
   localparam int COMP_W = $bits(comp_t);

   typedef struct packed {
      logic clamp_on;     // Supply clamp enabled while latched
      logic latchoff;     // Latch-off current sink enabled
      logic restart_mode; // Auto-recovery restart after overlong on-time
      logic skip_active;  // Burst operation holding pulses off
   } status_t;
endpackage

/* File: rtl/qr_sync2.sv */
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
`default_nettype none
module qr_sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   generate
      if (W < 1) begin : g_bad
         $error("qr_sync2 needs W of at least 1");
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/qr_interval_timer.sv */
// Retriggerable down-counter: busy for COUNT cycles after each start
`timescale 1ns/1ns
`default_nettype none
module qr_interval_timer #(
   parameter int COUNT = 160
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   output logic busy
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LOAD = CW'(COUNT);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic [CW-1:0] cnt;

   generate
      if (COUNT < 1) begin : g_bad
         $error("qr_interval_timer needs COUNT of at least 1");
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt <= '0;
      end else if (start) begin
         cnt <= LOAD;
      end else if (cnt != '0) begin
         cnt <= cnt - ONE;
      end
   end

   assign busy = (cnt != '0);
endmodule
`default_nettype wire

/* File: verif/power_stage_model.sv */
// Power stage model: current sense ramp and auxiliary winding ringing
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
   input wire logic sys_clk,
   input wire logic gate,
   input wire logic ring_en,
   input wire logic [11:0] on_cyc,
   input wire logic [7:0] demag_dly,
   output logic peak_hit,
   output logic demag_low
);
   int on_cnt = 0;
   int off_cnt = 0;
   always @(posedge sys_clk) begin
      on_cnt <= gate ? on_cnt + 1 : 0;
      off_cnt <= gate ? 0 : off_cnt + 1;
   end
   // Sense crosses the setpoint once the programmed on-time has run
   assign peak_hit = gate && on_cnt >= on_cyc;
   // Valleys every 40 cycles after core reset; a damped tank never crosses
   assign demag_low = ring_en && !gate && off_cnt >= demag_dly
      && ((off_cnt - demag_dly) % 40) < 20;
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the pulse sequencing core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import qr_pulse_pkg::*;
   localparam int SS = 512;
   localparam int RS = 512;
   typedef struct {int lo; int hi;} note_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   comp_t comparators;
   logic [SETPOINT_W-1:0] feedback_input = 8'h80;
   logic gate_drive_output;
   logic [SETPOINT_W-1:0] peak_setpoint;
   status_t status;
   logic peak_hit;
   logic demag_low;
   logic ring_en = 1'b1;
   logic [11:0] on_cyc = 12'h032;
   logic [7:0] demag_dly = 8'h64;
   // Bench-driven comparator levels, skip_low down to fault_timing
   logic [5:0] ctl = 6'h00;
   note_t notes[$];
   note_t n;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t_rise = -1000;
   int t_fall = -1000;
   int rel = 0;
   assign comparators = {peak_hit, demag_low, ctl};
   always #25 sys_clk = ~sys_clk;
   qr_pulse_control #(.SS_CYC(SS), .RESTART_CYC(RS)) qr_pulse_control_inst (
      .sys_clk(sys_clk), .rst(rst), .comparators(comparators),
      .feedback_input(feedback_input), .gate_drive_output(gate_drive_output),
      .peak_setpoint(peak_setpoint), .status(status));
   power_stage_model power_stage_model_inst (
      .sys_clk(sys_clk), .gate(gate_drive_output), .ring_en(ring_en),
      .on_cyc(on_cyc), .demag_dly(demag_dly), .peak_hit(peak_hit),
      .demag_low(demag_low));
   always @(posedge sys_clk) begin
      cyc++;
      if ($rose(gate_drive_output)) begin
         samples_checked++;
         if (cyc - t_rise < MIN_PERIOD_CYC || cyc - t_fall < BLANK_CYC) begin
            $display("wrong value gate_spacing expected %0d seen %0d", MIN_PERIOD_CYC,
               cyc - t_rise);
            miscompares++;
         end
         t_rise = cyc;
      end
      // The unknown-to-low step at power-up is not a real turn-off
      if ($fell(gate_drive_output) && !rst) begin
         t_fall = cyc;
         if (notes.size() > 0) begin
            n = notes.pop_front();
            samples_checked++;
            if (cyc - t_rise < n.lo || cyc - t_rise > n.hi) begin
               $display("wrong value on_time expected %0d seen %0d", n.lo, cyc - t_rise);
               miscompares++;
            end
         end
      end
   end
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(string what, logic [11:0] exp, logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic tk(int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // Pulse shape changes one edge after the last fall was seen, so that fall keeps its note
   task automatic pulse(int on, int dly, int lo, int hi);
      @(posedge sys_clk);
      while (gate_drive_output) @(posedge sys_clk);
      @(posedge sys_clk);
      on_cyc <= 12'(on);
      demag_dly <= 8'(dly);
      feedback_input <= 8'($urandom_range(255, 32));
      notes.push_back('{lo, hi});
      for (int i = 0; i < 3000 && notes.size() > 0; i++) tk(1);
      check("note_drained", 0, 12'(notes.size()));
   endtask
   task automatic hold_low(int k);
      int highs;
      highs = 0;
      repeat (k) begin
         tk(1);
         if (gate_drive_output !== 1'b0) highs++;
      end
      check("gate_held_low", 0, 12'(highs));
   endtask
   task automatic wait_rise(int lim);
      int t0;
      t0 = t_rise;
      for (int i = 0; i < lim && t_rise == t0; i++) tk(1);
      check("gate_rise", 1, 12'(t_rise != t0));
   endtask
   initial begin
      void'($urandom(32'h46364E31));
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         int on;
         on = $urandom_range(120, 20);
         pulse(on, $urandom_range(120, 5), on + 2, on + 5);
      end
      @(posedge sys_clk) ring_en <= 1'b0;
      pulse(60, 0, 62, 65);
      wait_rise(400);
      check("timeout_gap", 1, 12'(t_rise - t_fall >= TIMEOUT_CYC
         && t_rise - t_fall <= TIMEOUT_CYC + 6));
      @(posedge sys_clk) begin
         ring_en <= 1'b1;
         ctl <= 6'h20;
      end
      tk(6);
      hold_low(300);
      check("skip_active", 1, 12'(status.skip_active));
      // Threshold left but hysteresis not cleared: hold stays, valleys still ignored
      @(posedge sys_clk) ctl <= 6'h00;
      hold_low(200);
      check("skip_held", 1, 12'(status.skip_active));
      @(posedge sys_clk) ring_en <= 1'b0;
      tk(200);
      @(posedge sys_clk) ctl <= 6'h10;
      #1 rel = cyc;
      tk(7);
      check("ramp_restart", 1, 12'(peak_setpoint < 8'h05));
      check("skip_restart", 1, 12'(t_rise > rel && t_rise - rel <= 8));
      @(posedge sys_clk) begin
         ring_en <= 1'b1;
         feedback_input <= 8'h10;
      end
      tk(SS + 20);
      check("setpoint_floor", 12'(SETPOINT_FLOOR), 12'(peak_setpoint));
      @(posedge sys_clk) feedback_input <= 8'($urandom_range(254, 32));
      tk(3);
      check("setpoint_follow", 12'(feedback_input), 12'(peak_setpoint));
      @(posedge sys_clk) ctl <= 6'h12;
      tk(3);
      @(posedge sys_clk) ctl <= 6'h10;
      tk(4);
      check("clamp_on", 1, 12'(status.clamp_on));
      hold_low(200);
      @(posedge sys_clk) ctl <= 6'h14;
      tk(5);
      @(posedge sys_clk) ctl <= 6'h10;
      tk(4);
      check("clamp_released", 0, 12'(status.clamp_on));
      wait_rise(400);
      @(posedge sys_clk) ctl <= 6'h19;
      tk(6);
      check("latchoff", 1, 12'(status.latchoff));
      @(posedge sys_clk) ctl <= 6'h18;
      hold_low(100);
      @(posedge sys_clk) ctl <= 6'h10;
      tk(5);
      check("latchoff_clear", 0, 12'(status.latchoff));
      wait_rise(400);
      pulse(3000, 100, MAX_ON_CYC - 1, MAX_ON_CYC + 2);
      tk(3);
      check("restart_mode", 1, 12'(status.restart_mode));
      hold_low(RS - 20);
      wait_rise(400);
      tally_and_finish();
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
